// [inc/lsp_pkg.sv]
package lsp_pkg;
   // register pointer values
   localparam logic [7:0] PTR_RESULT = 8'h00;
   localparam logic [7:0] PTR_CONFIG = 8'h01;
   localparam logic [7:0] PTR_LOW = 8'h02;
   localparam logic [7:0] PTR_HIGH = 8'h03;
   localparam logic [7:0] PTR_MAKER = 8'h7e;
   localparam logic [7:0] PTR_PART = 8'h7f;
   // reset values
   localparam logic [15:0] CONFIG_RESET = 16'hc810;
   localparam logic [15:0] LOW_RESET = 16'h0000;
   localparam logic [15:0] HIGH_RESET = 16'hbfff;
   // writable bits of the configuration word
   localparam logic [15:0] CONFIG_WR_MASK = 16'hfe1f;
   // field positions in the configuration word
   localparam int CFG_READY_BIT = 7;
   localparam int CFG_FLAG_HIGH_BIT = 6;
   localparam int CFG_FLAG_LOW_BIT = 5;
   localparam int CFG_OVF_BIT = 8;
   localparam int CFG_LATCH_BIT = 4;
   localparam int CFG_POL_BIT = 3;
   // bus addresses
   localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
   localparam logic [7:0] GEN_CALL_RESET = 8'h06;
   localparam logic [6:0] ALERT_ADDR = 7'h0c;
   localparam logic [4:0] HS_CODE_TOP = 5'b0000_1;
   localparam logic [4:0] OWN_ADDR_TOP = 5'b1000_1;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // link states
   typedef enum logic [2:0] {
      LSP_IDLE = 3'b000,
      LSP_ADDR = 3'b001,
      LSP_AACK = 3'b011,
      LSP_WBYTE = 3'b010,
      LSP_WACK = 3'b110,
      LSP_RBYTE = 3'b111,
      LSP_RACK = 3'b101,
      LSP_IGNORE = 3'b100
   } lsp_state_t;
endpackage

// [src/lsp_target.sv]
`timescale 1ns/100ps
// Notes on behaviour
// - first written byte after address is pointer
// - ack address, pointer, two data bytes; store
// - pointer retained for all later reads
// - read sends high byte then low byte
// - nack or start releases data line
// - master code unacknowledged, switches to fast filter
// - stop returns filtering to standard speed
// - general call reset code restores defaults
// - alert address answered only when latched
// - alert: acknowledge, then send own address
// - lost arbitration withdraws, interrupt stays active
// - won arbitration clears interrupt output
// - high flag sent as address last bit
// - alert response leaves flags unchanged
// - six 16-bit registers at fixed pointers
// - result holds exponent and mantissa
// - interrupt pin level follows polarity field
// - configuration read clears ready flag
module lsp_target
   import lsp_pkg::*;
#(
   parameter logic [15:0] MAKER_CODE = 16'h1234, // arbitrary value
   parameter logic [15:0] PART_CODE = 16'h5678 // arbitrary value
) (
   // core clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // link clock and data line
   input wire logic scl_clk,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // strap for low address bits
   input wire logic [1:0] addr_strap,
   // measurement side
   input wire logic [15:0] conv_result,
   input wire logic conv_done,
   input wire logic flag_high_set,
   input wire logic flag_low_set,
   input wire logic [1:0] status_bits,
   // interrupt pin (open drain)
   output logic int_out,
   output logic int_oe,
   output logic hs_filter,
   output logic [15:0] config_word
);

   // ==========================================================
   // start and stop detection on the data line edges
   // ==========================================================
   // start: sda falls while scl high; stop: sda rises while scl high.
   // both are caught on the sda edge itself, since a start that follows
   // a stop brings no scl rise to sample the idle level with
   logic start_tog_r;
   logic start_old_r;
   logic start_seen_r;
   logic stop_tog_r;
   always_ff @(negedge sda_in or negedge rst_b) begin
      if (!rst_b) begin
         start_tog_r <= 1'b0;
      end else if (scl_clk) begin
         start_tog_r <= ~start_tog_r;
      end
   end
   // the toggle has settled for half a bit before the next scl fall
   always_ff @(negedge scl_clk or negedge rst_b) begin
      if (!rst_b) begin
         start_old_r <= 1'b0;
         start_seen_r <= 1'b0;
      end else begin
         start_old_r <= start_tog_r;
         start_seen_r <= start_tog_r ^ start_old_r;
      end
   end
   // a stop ends the frame, after which scl may stand still; the
   // stop is therefore detected on sda rising and crossed by toggle
   always_ff @(posedge sda_in or negedge rst_b) begin
      if (!rst_b) begin
         stop_tog_r <= 1'b0;
      end else if (scl_clk) begin
         stop_tog_r <= ~stop_tog_r;
      end
   end

   // ==========================================================
   // byte engine on the link clock
   // ==========================================================
   lsp_state_t state_r;
   logic [2:0] bit_cnt_r;
   logic [7:0] shift_r;
   logic [7:0] ptr_r;
   logic [1:0] wr_cnt_r;
   logic rd_high_r;
   logic is_read_r;
   logic is_gen_r;
   logic is_alert_r;
   logic [7:0] wr_high_r;
   logic [15:0] rd_word_r;
   logic alert_lost_r;
   logic hs_r;
   logic hs_tog_r;
   logic wr_tog_r;
   logic gc_tog_r;
   logic cfg_rd_tog_r;
   logic alert_tog_r;
   logic [15:0] wr_word_r;
   logic [7:0] wr_ptr_r;
   logic sda_drv_r;
   logic [6:0] own_addr;
   logic [15:0] sel_word;
   logic latch_link_r;
   logic latch_link_m_r;
   logic int_m_r;
   logic int_active_lk;
   logic flag_m_r;
   logic flag_high_lk;
   logic [15:0] cfg_r;
   logic int_active_r;

   assign own_addr = {OWN_ADDR_TOP, addr_strap};

   // latch field, interrupt state and high flag reach the link domain
   always_ff @(posedge scl_clk or negedge rst_b) begin
      if (!rst_b) begin
         latch_link_m_r <= 1'b0;
         latch_link_r <= 1'b0;
         int_m_r <= 1'b0;
         int_active_lk <= 1'b0;
         flag_m_r <= 1'b0;
         flag_high_lk <= 1'b0;
      end else begin
         latch_link_m_r <= config_word[CFG_LATCH_BIT];
         latch_link_r <= latch_link_m_r;
         int_m_r <= int_active_r;
         int_active_lk <= int_m_r;
         flag_m_r <= config_word[CFG_FLAG_HIGH_BIT];
         flag_high_lk <= flag_m_r;
      end
   end

   function automatic logic [15:0] reg_sel(input logic [7:0] p,
                                           input logic [15:0] res,
                                           input logic [15:0] cfg,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
      logic [15:0] v;
      v = 16'h0000;
      case (p)
         PTR_RESULT: v = res;
         PTR_CONFIG: v = cfg;
         PTR_LOW: v = lo;
         PTR_HIGH: v = hi;
         PTR_MAKER: v = MAKER_CODE;
         PTR_PART: v = PART_CODE;
         default: v = 16'h0000;
      endcase
      return v;
   endfunction

   logic [15:0] result_r;
   logic [15:0] low_r;
   logic [15:0] high_r;
   assign sel_word = reg_sel(ptr_r, result_r, config_word, low_r,
                             high_r);

   // state advances on the rising edge where data is sampled
   always_ff @(posedge scl_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= LSP_IDLE;
         bit_cnt_r <= 3'h0;
         shift_r <= 8'h00;
         ptr_r <= PTR_RESULT;
         wr_cnt_r <= 2'h0;
         rd_high_r <= 1'b1;
         is_read_r <= 1'b0;
         is_gen_r <= 1'b0;
         is_alert_r <= 1'b0;
         wr_high_r <= 8'h00;
         rd_word_r <= 16'h0000;
         alert_lost_r <= 1'b0;
         hs_tog_r <= 1'b0;
         wr_tog_r <= 1'b0;
         gc_tog_r <= 1'b0;
         cfg_rd_tog_r <= 1'b0;
         alert_tog_r <= 1'b0;
         wr_word_r <= 16'h0000;
         wr_ptr_r <= 8'h00;
      end else begin
         if (start_seen_r) begin
            // first address bit sampled on this edge; also ends any
            // read in progress
            state_r <= LSP_ADDR;
            shift_r <= {7'h00, sda_in};
            bit_cnt_r <= 3'h1;
         end else begin
            case (state_r)
               LSP_ADDR: begin
                  shift_r <= {shift_r[6:0], sda_in};
                  bit_cnt_r <= bit_cnt_r + 3'h1;
                  if (bit_cnt_r == BIT_LAST) begin
                     is_read_r <= sda_in;
                     is_gen_r <= 1'b0;
                     is_alert_r <= 1'b0;
                     wr_cnt_r <= 2'h0;
                     rd_high_r <= 1'b1;
                     alert_lost_r <= 1'b0;
                     if (shift_r[6:2] == HS_CODE_TOP) begin
                        hs_tog_r <= ~hs_tog_r;
                        state_r <= LSP_IGNORE;
                     end else if (shift_r[6:0] == own_addr) begin
                        state_r <= LSP_AACK;
                     end else if (shift_r[6:0] == GEN_CALL_ADDR &&
                                  !sda_in) begin
                        is_gen_r <= 1'b1;
                        state_r <= LSP_AACK;
                     end else if (shift_r[6:0] == ALERT_ADDR && sda_in &&
                                  latch_link_r && int_active_lk) begin
                        is_alert_r <= 1'b1;
                        state_r <= LSP_AACK;
                     end else begin
                        state_r <= LSP_IGNORE;
                     end
                  end
               end
               LSP_AACK: begin
                  bit_cnt_r <= 3'h0;
                  if (is_alert_r) begin
                     rd_word_r <= {own_addr,
                        flag_high_lk, 8'h00};
                     state_r <= LSP_RBYTE;
                  end else if (is_read_r) begin
                     rd_word_r <= sel_word;
                     state_r <= LSP_RBYTE;
                  end else begin
                     state_r <= LSP_WBYTE;
                  end
               end
               LSP_WBYTE: begin
                  shift_r <= {shift_r[6:0], sda_in};
                  bit_cnt_r <= bit_cnt_r + 3'h1;
                  if (bit_cnt_r == BIT_LAST) begin
                     state_r <= LSP_WACK;
                  end
               end
               LSP_WACK: begin
                  bit_cnt_r <= 3'h0;
                  state_r <= LSP_WBYTE;
                  if (is_gen_r) begin
                     if (shift_r == GEN_CALL_RESET) begin
                        gc_tog_r <= ~gc_tog_r;
                     end
                     state_r <= LSP_IGNORE;
                  end else if (wr_cnt_r == 2'h0) begin
                     ptr_r <= shift_r;
                     wr_cnt_r <= 2'h1;
                  end else if (wr_cnt_r == 2'h1) begin
                     wr_high_r <= shift_r;
                     wr_cnt_r <= 2'h2;
                  end else begin
                     wr_word_r <= {wr_high_r, shift_r};
                     wr_ptr_r <= ptr_r;
                     wr_tog_r <= ~wr_tog_r;
                     wr_cnt_r <= 2'h1;
                  end
               end
               LSP_RBYTE: begin
                  bit_cnt_r <= bit_cnt_r + 3'h1;
                  if (is_alert_r && !sda_in && !sda_drv_r) begin
                     alert_lost_r <= 1'b1;
                  end
                  if (bit_cnt_r == BIT_LAST) begin
                     state_r <= LSP_RACK;
                  end
               end
               LSP_RACK: begin
                  bit_cnt_r <= 3'h0;
                  if (is_alert_r) begin
                     if (!alert_lost_r) begin
                        alert_tog_r <= ~alert_tog_r;
                     end
                     state_r <= LSP_IGNORE;
                  end else begin
                     // a finished word counts as read, acked or not
                     if (!rd_high_r && ptr_r == PTR_CONFIG) begin
                        cfg_rd_tog_r <= ~cfg_rd_tog_r;
                     end
                     if (sda_in) begin
                        state_r <= LSP_IGNORE;
                     end else if (rd_high_r) begin
                        rd_high_r <= 1'b0;
                        state_r <= LSP_RBYTE;
                     end else begin
                        rd_high_r <= 1'b1;
                        rd_word_r <= sel_word;
                        state_r <= LSP_RBYTE;
                     end
                  end
               end
               default: state_r <= state_r;
            endcase
         end
      end
   end

   // data line changes on the falling edge of scl
   logic [7:0] tx_byte;
   assign tx_byte = rd_high_r ? rd_word_r[15:8] : rd_word_r[7:0];
   always_ff @(negedge scl_clk or negedge rst_b) begin
      if (!rst_b) begin
         sda_drv_r <= 1'b0;
      end else begin
         case (state_r)
            // only accepted addresses reach this state
            LSP_AACK: sda_drv_r <= 1'b1;
            LSP_WACK: sda_drv_r <= !(is_gen_r && shift_r != GEN_CALL_RESET);
            LSP_RBYTE: sda_drv_r <= !alert_lost_r &&
               !tx_byte[BIT_LAST - bit_cnt_r];
            default: sda_drv_r <= 1'b0;
         endcase
      end
   end
   assign sda_out = 1'b0;
   assign sda_oe = sda_drv_r & (state_r != LSP_IDLE);
   assign hs_filter = hs_r;

   // ==========================================================
   // register file on the core clock
   // ==========================================================
   logic [2:0] wr_sync_r;
   logic [2:0] gc_sync_r;
   logic [2:0] rd_sync_r;
   logic [2:0] al_sync_r;
   logic [2:0] hs_sync_r;
   logic [2:0] stp_sync_r;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_sync_r <= 3'h0;
         gc_sync_r <= 3'h0;
         rd_sync_r <= 3'h0;
         al_sync_r <= 3'h0;
         hs_sync_r <= 3'h0;
         stp_sync_r <= 3'h0;
      end else begin
         wr_sync_r <= {wr_sync_r[1:0], wr_tog_r};
         gc_sync_r <= {gc_sync_r[1:0], gc_tog_r};
         rd_sync_r <= {rd_sync_r[1:0], cfg_rd_tog_r};
         al_sync_r <= {al_sync_r[1:0], alert_tog_r};
         hs_sync_r <= {hs_sync_r[1:0], hs_tog_r};
         stp_sync_r <= {stp_sync_r[1:0], stop_tog_r};
      end
   end
   logic wr_ev;
   logic gc_ev;
   logic rd_ev;
   logic al_ev;
   assign wr_ev = wr_sync_r[2] ^ wr_sync_r[1];
   assign gc_ev = gc_sync_r[2] ^ gc_sync_r[1];
   assign rd_ev = rd_sync_r[2] ^ rd_sync_r[1];
   assign al_ev = al_sync_r[2] ^ al_sync_r[1];
   logic hs_ev;
   logic stp_ev;
   assign hs_ev = hs_sync_r[2] ^ hs_sync_r[1];
   assign stp_ev = stp_sync_r[2] ^ stp_sync_r[1];

   // filter select lives here: after a stop scl may stand still
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         hs_r <= 1'b0;
      end else if (hs_ev) begin
         hs_r <= 1'b1;
      end else if (stp_ev) begin
         hs_r <= 1'b0;
      end
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         result_r <= 16'h0000;
      end else if (gc_ev) begin
         result_r <= 16'h0000;
      end else if (conv_done) begin
         result_r <= conv_result;
      end
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         low_r <= LOW_RESET;
         high_r <= HIGH_RESET;
      end else if (gc_ev) begin
         low_r <= LOW_RESET;
         high_r <= HIGH_RESET;
      end else if (wr_ev && wr_ptr_r == PTR_LOW) begin
         low_r <= wr_word_r;
      end else if (wr_ev && wr_ptr_r == PTR_HIGH) begin
         high_r <= wr_word_r;
      end
   end
   // flag sets win over the read clear
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_r <= CONFIG_RESET;
      end else if (gc_ev) begin
         cfg_r <= CONFIG_RESET;
      end else begin
         if (wr_ev && wr_ptr_r == PTR_CONFIG) begin
            cfg_r <= (cfg_r & ~CONFIG_WR_MASK) |
                     (wr_word_r & CONFIG_WR_MASK);
         end else if (rd_ev) begin
            cfg_r[CFG_READY_BIT] <= 1'b0;
         end
         if (conv_done) begin
            cfg_r[CFG_READY_BIT] <= 1'b1;
         end
         if (flag_high_set) begin
            cfg_r[CFG_FLAG_HIGH_BIT] <= 1'b1;
         end
         if (flag_low_set) begin
            cfg_r[CFG_FLAG_LOW_BIT] <= 1'b1;
         end
         cfg_r[CFG_OVF_BIT] <= status_bits[0];
      end
   end
   assign config_word = cfg_r;

   // interrupt: raised by a flag event, cleared by alert win or reset
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         int_active_r <= 1'b0;
      end else if (flag_high_set || flag_low_set) begin
         int_active_r <= 1'b1;
      end else if (gc_ev || al_ev) begin
         int_active_r <= 1'b0;
      end
   end
   // pin low when active with polarity 0, or inactive with polarity 1
   assign int_out = 1'b0;
   assign int_oe = int_active_r ^ cfg_r[CFG_POL_BIT];

endmodule

// [dv/lsp_target_asserts.sv]
`timescale 1ns/100ps
// ====
// port checker for the light sensor register port
module lsp_target_asserts
   import lsp_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // bus side
   input wire logic scl_clk,
   input wire logic sda_in,
   input wire logic hs_filter,
   // measurement side
   input wire logic conv_done,
   input wire logic flag_high_set,
   input wire logic flag_low_set,
   // outputs
   input wire logic int_out,
   input wire logic int_oe,
   input wire logic [15:0] config_word
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   a_reset_defaults:
      assert property ($rose(rst_b) |->
         config_word == CONFIG_RESET && !hs_filter && !int_oe)
      else $error("reset defaults wrong");
   a_int_pin_low:
      assert property (int_out == 1'b0)
      else $error("int output not low");
   a_ready_on_done:
      assert property (conv_done |-> ##[1:4] config_word[CFG_READY_BIT])
      else $error("ready flag not set after conversion");
   a_ready_cause:
      assert property ($rose(config_word[CFG_READY_BIT]) |->
         $past(conv_done) || $past(conv_done, 2) ||
         $past(conv_done, 3) || $past(conv_done, 4))
      else $error("ready flag set without conversion");
   a_high_cause:
      assert property ($rose(config_word[CFG_FLAG_HIGH_BIT]) |->
         $past(flag_high_set) || $past(flag_high_set, 2) ||
         $past(flag_high_set, 3) || $past(flag_high_set, 4))
      else $error("high flag set without cause");
   a_low_cause:
      assert property ($rose(config_word[CFG_FLAG_LOW_BIT]) |->
         $past(flag_low_set) || $past(flag_low_set, 2) ||
         $past(flag_low_set, 3) || $past(flag_low_set, 4))
      else $error("low flag set without cause");
   a_int_active_pol:
      assert property ($rose(flag_high_set) |-> ##[1:4]
         int_oe == !config_word[CFG_POL_BIT])
      else $error("int pin level wrong when active");
   // three high samples of scl after the sda rise rule out a data bit
   a_hs_stop_exit:
      assert property ($past(hs_filter) && scl_clk && $rose(sda_in) ##1
         (scl_clk && sda_in) [*3] |-> ##[0:4] !hs_filter)
      else $error("high speed filter kept after stop");
endmodule

bind lsp_target lsp_target_asserts i_lsp_target_asserts (.core_clk,
   .rst_b, .scl_clk, .sda_in, .hs_filter, .conv_done, .flag_high_set,
   .flag_low_set, .int_out, .int_oe, .config_word);

// [dv/lsp_master.sv]
`timescale 1ns/100ps
// ====
// two-wire bus master model, scl idles high outside frames
module lsp_master (
   // bus lines
   output logic scl_clk,
   output logic sda_pull,
   input wire logic sda_line
);
   localparam int HALF = 16;

   initial begin
      scl_clk = 1'b1;
      sda_pull = 1'b0;
   end

   // sda stays released, so no start or stop is seen
   task automatic clocks(input int n);
      repeat (n) begin
         #HALF scl_clk = 1'b0;
         #HALF scl_clk = 1'b1;
      end
   endtask

   // also the repeated start that keeps high speed
   task automatic start();
      #4 sda_pull = 1'b0;
      #HALF scl_clk = 1'b1;
      #HALF sda_pull = 1'b1;
      #HALF scl_clk = 1'b0;
   endtask

   task automatic stop();
      #4 sda_pull = 1'b1;
      #HALF scl_clk = 1'b1;
      #HALF sda_pull = 1'b0;
      #(4 * HALF);
   endtask

   // data moves 4 ns after the fall, clear of start detection
   task automatic xbit(input logic b, output logic r);
      #4 sda_pull = !b;
      #HALF scl_clk = 1'b1;
      r = sda_line;
      #HALF scl_clk = 1'b0;
   endtask

   // zeros in d pull the line, as a competing sender would
   task automatic xbyte(input logic [7:0] d, input logic nak,
                        output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xbit(d[i], q[i]);
      end
      xbit(nak, r);
      ack = !r;
   endtask
endmodule

// [dv/lsp_target_tb.sv]
`timescale 1ns/100ps
module lsp_target_tb;
   import lsp_pkg::*;
   // ====
   // bench identity codes, values arbitrary
   localparam logic [15:0] MK = 16'h1a2b;
   localparam logic [15:0] PT = 16'h3c4d;
   localparam logic [7:0] OWN_W = {OWN_ADDR_TOP, 2'h2, 1'b0};
   logic core_clk, rst_b, scl_clk, pull, sda_out, sda_oe, ak;
   logic conv_done, flag_high_set, flag_low_set, int_out, int_oe;
   logic hs_filter;
   logic [15:0] conv_result, config_word, rv;
   logic [7:0] q;
   wire sda;
   int bad_count = 0;
   int checked = 0;

   // pull-up on the data line
   assign sda = !(sda_oe || pull);

   lsp_target #(.MAKER_CODE(MK), .PART_CODE(PT)) i_lsp_target (
      .core_clk, .rst_b, .scl_clk, .sda_in(sda), .sda_out, .sda_oe,
      .addr_strap(2'h2), .conv_result, .conv_done, .flag_high_set,
      .flag_low_set, .status_bits(2'h0), .int_out, .int_oe, .hs_filter,
      .config_word);
   lsp_master i_lsp_master (.scl_clk, .sda_pull(pull), .sda_line(sda));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = !core_clk;
   end

   // ====
   // tasks
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wait_core(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic sb(input logic [7:0] d, input logic e);
      i_lsp_master.xbyte(d, 1'b1, q, ak);
      chk({15'h0, ak}, {15'h0, e});
   endtask

   task automatic wr(input logic [7:0] p, input logic [15:0] d,
                     input logic two);
      i_lsp_master.start();
      sb(OWN_W, 1'b1);
      sb(p, 1'b1);
      if (two) begin
         sb(d[15:8], 1'b1);
         sb(d[7:0], 1'b1);
      end
      i_lsp_master.stop();
      wait_core(8);
   endtask

   task automatic rd(input logic [15:0] e);
      i_lsp_master.start();
      sb(OWN_W | 8'h01, 1'b1);
      i_lsp_master.xbyte(8'hff, 1'b0, q, ak);
      rv[15:8] = q;
      i_lsp_master.xbyte(8'hff, 1'b1, q, ak);
      rv[7:0] = q;
      #2 chk({15'h0, sda_oe}, 16'h0000);
      i_lsp_master.stop();
      wait_core(4);
      chk(rv, e);
   endtask

   task automatic alert(input logic e, input logic [7:0] pat);
      i_lsp_master.start();
      sb({ALERT_ADDR, 1'b1}, e);
      if (e) begin
         i_lsp_master.xbyte(pat, 1'b1, q, ak);
      end
      i_lsp_master.stop();
      wait_core(6);
   endtask

   task automatic pulse(input logic hi, input logic lo);
      @(negedge core_clk);
      flag_high_set = hi;
      flag_low_set = lo;
      @(negedge core_clk);
      flag_high_set = 1'b0;
      flag_low_set = 1'b0;
      wait_core(6);
   endtask

   initial begin
      #500000;
      bad_count++;
      stop_test();
   end

   // ====
   // main sequence
   initial begin
      rst_b = 1'b0;
      conv_result = 16'h0000;
      conv_done = 1'b0;
      flag_high_set = 1'b0;
      flag_low_set = 1'b0;
      fork
         i_lsp_master.clocks(4);
      join_none
      wait_core(16);
      rst_b = 1'b1;
      i_lsp_master.clocks(4);
      chk(config_word, CONFIG_RESET);
      chk({14'h0, hs_filter, int_oe}, 16'h0000);
      wr(PTR_MAKER, 16'h0000, 1'b0);
      rd(MK);
      rd(MK);
      wr(PTR_PART, 16'h0000, 1'b0);
      rd(PT);
      wr(PTR_LOW, 16'ha55a, 1'b1);
      wr(PTR_HIGH, 16'h5aa5, 1'b1);
      rd(16'h5aa5);
      wr(PTR_LOW, 16'h0000, 1'b0);
      rd(16'ha55a);
      @(negedge core_clk);
      conv_result = 16'hb001;
      conv_done = 1'b1;
      @(negedge core_clk);
      conv_done = 1'b0;
      wr(PTR_RESULT, 16'h0f0f, 1'b1);
      rd(16'hb001);
      wr(PTR_CONFIG, 16'h0000, 1'b0);
      rd(CONFIG_RESET | 16'h0080);
      rd(CONFIG_RESET);
      // read-only bits are all clear at this point
      wr(PTR_CONFIG, 16'hffff, 1'b1);
      chk(config_word, CONFIG_WR_MASK);
      chk({15'h0, int_oe}, 16'h0001);
      wr(PTR_CONFIG, 16'hc800, 1'b1);
      pulse(1'b1, 1'b0);
      chk({15'h0, int_oe}, 16'h0001);
      alert(1'b0, 8'hff);
      wr(PTR_CONFIG, 16'hc818, 1'b1);
      pulse(1'b1, 1'b1);
      chk(config_word, 16'hc878);
      chk({15'h0, int_oe}, 16'h0000);
      alert(1'b1, 8'h7f);
      chk({15'h0, int_oe}, 16'h0000);
      alert(1'b1, 8'hff);
      chk({8'h00, q}, {8'h00, OWN_ADDR_TOP, 2'h2, 1'b1});
      chk({15'h0, int_oe}, 16'h0001);
      chk(config_word, 16'hc878);
      i_lsp_master.start();
      sb(8'h90, 1'b0);
      i_lsp_master.stop();
      i_lsp_master.start();
      sb(8'h0b, 1'b0);
      wait_core(4);
      chk({15'h0, hs_filter}, 16'h0001);
      rd(16'hc878);
      chk({15'h0, hs_filter}, 16'h0000);
      i_lsp_master.start();
      sb(8'h00, 1'b1);
      sb(GEN_CALL_RESET, 1'b1);
      i_lsp_master.stop();
      wait_core(8);
      chk(config_word, CONFIG_RESET);
      wr(PTR_HIGH, 16'h0000, 1'b0);
      rd(HIGH_RESET);
      stop_test();
   end
endmodule
